//--- design/fcps_defs.svh
// Constants of the floppy command-phase sequencer.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef FCPS_DEFS_SVH
`define FCPS_DEFS_SVH

// =====================================================================
// Command codes and the invalid-command status byte
`define FCPS_VERIFY_CODE   5'h16
`define FCPS_WRITE_CODE    6'h05
`define FCPS_WRDEL_CODE    6'h09
`define FCPS_RECAL_CODE    8'h07
`define FCPS_SENSE_CODE    8'h08
`define FCPS_INVALID_ST0   8'h80

// =====================================================================
// Bit positions and interrupt codes
`define FCPS_MT_BIT        7
`define FCPS_MFM_BIT       6
`define FCPS_EC_BIT        7
`define FCPS_HDS_BIT       2
`define FCPS_SE_BIT        5
`define FCPS_EQC_BIT       4
`define FCPS_DERR_BIT      5
`define FCPS_IC_ABNORMAL   2'h1
`define FCPS_IC_NORMAL     2'h0

// =====================================================================
// Parameter slots, counts and first record number
`define FCPS_SLOT_DRV      3'h0
`define FCPS_SLOT_CYL      3'h1
`define FCPS_SLOT_HEAD     3'h2
`define FCPS_SLOT_REC      3'h3
`define FCPS_SLOT_SIZE     3'h4
`define FCPS_SLOT_EOT      3'h5
`define FCPS_SLOT_GAP      3'h6
`define FCPS_SLOT_LAST     3'h7
`define FCPS_SECT_PARAMS   4'h8
`define FCPS_RECAL_PARAMS  4'h1
`define FCPS_SECT_RESULTS  3'h7
`define FCPS_SENSE_RESULTS 3'h2
`define FCPS_INV_RESULTS   3'h1
`define FCPS_FIRST_REC     8'h01

// =====================================================================
// Timing
`define FCPS_CLK_HZ        20000000
`define FCPS_STEP_NS       4000
`define FCPS_STEP_CYC      (((`FCPS_STEP_NS * (`FCPS_CLK_HZ / 1000000)) + 999) / 1000)
`define FCPS_RECAL_STEPS   255

`endif

//--- design/fcps_pkg.sv
// Types of the floppy command-phase sequencer.
// Assumes fcps_defs.svh is compiled alongside.
package fcps_pkg;

  typedef enum logic [2:0] {
    FCPS_IDLE   = 3'b000,
    FCPS_PARAM  = 3'b001,
    FCPS_EXEC   = 3'b010,
    FCPS_STEP   = 3'b011,
    FCPS_RESULT = 3'b100
  } fcps_state_e;

  typedef enum logic [2:0] {
    FCPS_OP_VERIFY = 3'b000,
    FCPS_OP_WRITE  = 3'b001,
    FCPS_OP_WRDEL  = 3'b010,
    FCPS_OP_RECAL  = 3'b011,
    FCPS_OP_SENSE  = 3'b100,
    FCPS_OP_BAD    = 3'b101
  } fcps_op_e;

endpackage

//--- design/fcps_fifo.sv
// Sector-data FIFO between host and drive, with registered read data.
// Assumes DEPTH is a power of two and one clock for both sides.
`timescale 1ns/1ps
module fcps_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             clock_i,
  input  wire logic             rstn_i,
  input  wire logic             flush_i,
  // Fill side
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  // Drain side
  output logic [WIDTH-1:0]      out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr, next_wr_ptr;
  logic [AW-1:0]    rd_ptr, next_rd_ptr;
  logic [AW:0]      cnt, next_cnt;
  logic             next_out_valid;
  logic [WIDTH-1:0] next_out_data;
  logic             push;
  logic             load;

  // =====================================================================
  // Next state
  assign in_ready_o = (cnt != DEPTH[AW:0]);
  assign push       = in_valid_i && in_ready_o;
  assign load       = (cnt != '0) && (!out_valid_o || out_ready_i);

  always_comb begin
    next_wr_ptr    = push ? AW'(wr_ptr + 1'b1) : wr_ptr;
    next_rd_ptr    = load ? AW'(rd_ptr + 1'b1) : rd_ptr;
    next_cnt       = (AW+1)'(cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, load});
    next_out_valid = load ? 1'b1 : (out_ready_i ? 1'b0 : out_valid_o);
    next_out_data  = load ? mem[rd_ptr] : out_data_o;
    if (flush_i) begin
      next_wr_ptr    = '0;
      next_rd_ptr    = '0;
      next_cnt       = '0;
      next_out_valid = 1'b0;
    end
  end

  // =====================================================================
  // Registers
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      wr_ptr      <= '0;
      rd_ptr      <= '0;
      cnt         <= '0;
      out_valid_o <= 1'b0;
      out_data_o  <= '0;
    end else begin
      wr_ptr      <= next_wr_ptr;
      rd_ptr      <= next_rd_ptr;
      cnt         <= next_cnt;
      out_valid_o <= next_out_valid;
      out_data_o  <= next_out_data;
    end
  end

  // Storage needs no reset; count guards every read
  always_ff @(posedge clock_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end
endmodule

//--- design/fcps_sequencer.sv
// Command, execution and result phases of a floppy controller.
// Assumes a host byte port, a drive that reports each sector, one clock.
//
// Operation
// [RULE1] Verify takes the full address list, checks sectors without moving data, and bit 7 of byte two picks length or count.
// [RULE2] Write and write-deleted carry multi-track in bit 7 and density in bit 6 and move sector bytes to the drive.
// [RULE3] The host writes the drive and head byte, then cylinder, head, record, size, final sector, gap and length.
// [RULE4] A finished sector command offers three status bytes then cylinder, head, record and size reached.
// [RULE5] Recalibrate takes one drive byte, steps that head to track 0 and interrupts with no result phase.
// [RULE6] Sense interrupt status after a seek answers with the first status byte and the present cylinder.
// [RULE7] An unknown command does nothing, returns to standby and yields one status byte of 80H.
// [RULE8] The host reads result bytes only while the device shows its port ready for reading.
`timescale 1ns/1ps
`include "fcps_defs.svh"
module fcps_sequencer #(
  parameter int STEP_CYC    = `FCPS_STEP_CYC,
  parameter int RECAL_STEPS = `FCPS_RECAL_STEPS,
  parameter int FIFO_DEPTH  = 8
) (
  // Clock and reset
  input  wire logic       clock_i,
  input  wire logic       rstn_i,
  // Host command and result port
  input  wire logic [7:0] host_data_i,
  input  wire logic       host_wr_i,
  output logic            host_wr_ready_o,
  output logic [7:0]      host_data_o,
  input  wire logic       host_rd_i,
  output logic            host_rd_ready_o,
  output logic            busy_o,
  output logic            exec_o,
  output logic            int_o,
  // Host sector data
  input  wire logic [7:0] xfer_data_i,
  input  wire logic       xfer_valid_i,
  output logic            xfer_ready_o,
  // Drive side
  output logic [7:0]      drv_data_o,
  output logic            drv_valid_o,
  input  wire logic       drv_ready_i,
  input  wire logic       drv_sector_done_i,
  input  wire logic       drv_sector_err_i,
  input  wire logic       drv_track0_i,
  output logic [1:0]      drv_sel_o,
  output logic            drv_head_o,
  output logic [7:0]      drv_cyl_o,
  output logic [7:0]      drv_rec_o,
  output logic [7:0]      drv_size_o,
  output logic [7:0]      drv_gap_o,
  output logic            drv_dens_o,
  output logic            drv_write_o,
  output logic            drv_deleted_o,
  output logic            drv_verify_o,
  output logic            drv_step_o,
  output logic            drv_dir_o
);
  import fcps_pkg::*;

  fcps_state_e state, next_state;
  fcps_op_e    op, next_op;
  logic [7:0]  param [8];
  logic [7:0]  next_param [8];
  logic [7:0]  present_cylinder [4];
  logic [7:0]  next_pcn [4];
  logic [3:0]  pidx, next_pidx, pneed, next_pneed;
  logic        multi_track_flag, next_multi_track_flag;
  logic        double_density_flag, next_double_density_flag;
  logic        length_or_count_choice, next_length_or_count_choice;
  logic [7:0]  sect_cnt, next_sect_cnt;
  logic [7:0]  result_status_first, next_result_status_first;
  logic [7:0]  result_status_second, next_result_status_second;
  logic [7:0]  seek_status, next_seek_status;
  logic [1:0]  seek_drive, next_seek_drive;
  logic        seek_pend, next_seek_pend;
  logic [2:0]  res_idx, next_res_idx, res_len, next_res_len;
  logic        res_ok, next_res_ok;
  logic [7:0]  next_host_data;
  logic        next_int;
  logic [15:0] step_cnt, next_step_cnt;
  logic [7:0]  steps, next_steps;
  logic        next_step;
  logic [7:0]  res_byte;
  logic        is_write, pop, last_sect, head_side_choice;
  logic [1:0]  drive_pick;
  logic        fifo_in_ready, fifo_out_valid, fifo_flush;

  // =====================================================================
  // Sector data path
  assign is_write     = (state == FCPS_EXEC) && ((op == FCPS_OP_WRITE) || (op == FCPS_OP_WRDEL));
  assign xfer_ready_o = is_write && fifo_in_ready;
  assign drv_valid_o  = is_write && fifo_out_valid;
  assign fifo_flush   = !is_write;

  // Host stalls on xfer_ready_o when the drive drains slowly
  fcps_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock_i     (clock_i),
    .rstn_i      (rstn_i),
    .flush_i     (fifo_flush),
    .in_data_i   (xfer_data_i),
    .in_valid_i  (xfer_valid_i && is_write),
    .in_ready_o  (fifo_in_ready),
    .out_data_o  (drv_data_o),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (drv_ready_i && is_write)
  );

  // =====================================================================
  // Drive controls
  assign drive_pick       = param[`FCPS_SLOT_DRV][1:0];
  assign head_side_choice = param[`FCPS_SLOT_DRV][`FCPS_HDS_BIT];
  assign drv_sel_o        = drive_pick;
  assign drv_head_o       = head_side_choice;
  assign drv_cyl_o        = param[`FCPS_SLOT_CYL];
  assign drv_rec_o        = param[`FCPS_SLOT_REC];
  assign drv_size_o       = param[`FCPS_SLOT_SIZE];
  assign drv_gap_o        = param[`FCPS_SLOT_GAP];
  assign drv_dens_o       = double_density_flag;
  assign drv_write_o      = is_write;
  assign drv_deleted_o    = is_write && (op == FCPS_OP_WRDEL);
  assign drv_verify_o     = (state == FCPS_EXEC) && (op == FCPS_OP_VERIFY); // RULE1
  assign drv_dir_o        = 1'b0;
  assign busy_o           = (state != FCPS_IDLE);
  assign exec_o           = (state == FCPS_EXEC) || (state == FCPS_STEP);
  assign host_wr_ready_o  = (state == FCPS_IDLE) || (state == FCPS_PARAM);
  assign host_rd_ready_o  = (state == FCPS_RESULT) && res_ok; // RULE8
  assign pop              = host_rd_i && host_rd_ready_o;

  // For verify, final parameter is a sector count when the choice bit is set
  assign last_sect = (op == FCPS_OP_VERIFY) && length_or_count_choice ?
                     (8'(sect_cnt + 1'b1) == param[`FCPS_SLOT_LAST]) :
                     (param[`FCPS_SLOT_REC] == param[`FCPS_SLOT_EOT]); // RULE1

  // =====================================================================
  // Result byte selection
  always_comb begin
    res_byte = 8'h00;
    if (op == FCPS_OP_BAD) begin
      res_byte = `FCPS_INVALID_ST0; // RULE7
    end else if (op == FCPS_OP_SENSE) begin
      res_byte = (res_idx == 3'h0) ? seek_status : present_cylinder[seek_drive]; // RULE6
    end else begin
      unique case (res_idx)
        3'h0:    res_byte = result_status_first; // RULE4
        3'h1:    res_byte = result_status_second;
        3'h2:    res_byte = 8'h00;
        3'h3:    res_byte = param[`FCPS_SLOT_CYL];
        3'h4:    res_byte = param[`FCPS_SLOT_HEAD];
        3'h5:    res_byte = param[`FCPS_SLOT_REC];
        default: res_byte = param[`FCPS_SLOT_SIZE];
      endcase
    end
  end

  // =====================================================================
  // Sequencer next state
  always_comb begin
    next_state                  = state;
    next_op                     = op;
    next_param                  = param;
    next_pcn                    = present_cylinder;
    next_pidx                   = pidx;
    next_pneed                  = pneed;
    next_multi_track_flag       = multi_track_flag;
    next_double_density_flag    = double_density_flag;
    next_length_or_count_choice = length_or_count_choice;
    next_sect_cnt               = sect_cnt;
    next_result_status_first    = result_status_first;
    next_result_status_second   = result_status_second;
    next_seek_status            = seek_status;
    next_seek_drive             = seek_drive;
    next_seek_pend              = seek_pend;
    next_res_idx                = res_idx;
    next_res_len                = res_len;
    next_res_ok                 = 1'b0;
    next_host_data              = host_data_o;
    next_int                    = int_o;
    next_step_cnt               = step_cnt;
    next_steps                  = steps;
    next_step                   = 1'b0;
    unique case (state)
      FCPS_IDLE: begin
        if (host_wr_i) begin
          next_pidx     = 4'h0;
          next_res_idx  = 3'h0;
          next_sect_cnt = 8'h00;
          next_multi_track_flag    = host_data_i[`FCPS_MT_BIT]; // RULE2
          next_double_density_flag = host_data_i[`FCPS_MFM_BIT]; // RULE2
          next_pneed = `FCPS_SECT_PARAMS;
          next_state = FCPS_PARAM;
          if (host_data_i[4:0] == `FCPS_VERIFY_CODE) begin
            next_op = FCPS_OP_VERIFY; // RULE1
          end else if (host_data_i[5:0] == `FCPS_WRITE_CODE) begin
            next_op = FCPS_OP_WRITE; // RULE2
          end else if (host_data_i[5:0] == `FCPS_WRDEL_CODE) begin
            next_op = FCPS_OP_WRDEL; // RULE2
          end else if (host_data_i == `FCPS_RECAL_CODE) begin
            next_op    = FCPS_OP_RECAL; // RULE5
            next_pneed = `FCPS_RECAL_PARAMS;
          end else if ((host_data_i == `FCPS_SENSE_CODE) && seek_pend) begin
            next_op      = FCPS_OP_SENSE; // RULE6
            next_res_len = `FCPS_SENSE_RESULTS;
            next_state   = FCPS_RESULT;
            next_seek_pend = 1'b0;
            next_int     = 1'b0;
          end else begin
            // Sense with nothing pending is treated as unknown
            next_op      = FCPS_OP_BAD; // RULE7
            next_res_len = `FCPS_INV_RESULTS;
            next_state   = FCPS_RESULT;
          end
        end
      end
      FCPS_PARAM: begin
        if (host_wr_i) begin
          next_param[pidx[2:0]] = host_data_i; // RULE3
          next_pidx = 4'(pidx + 1'b1);
          if (4'(pidx + 1'b1) == pneed) begin
            next_length_or_count_choice = next_param[`FCPS_SLOT_DRV][`FCPS_EC_BIT]; // RULE1
            next_state    = (op == FCPS_OP_RECAL) ? FCPS_STEP : FCPS_EXEC;
            next_step_cnt = 16'h0000;
            next_steps    = 8'h00;
          end
        end
      end
      FCPS_EXEC: begin
        if (drv_sector_done_i) begin
          next_sect_cnt = 8'(sect_cnt + 1'b1);
          next_result_status_first  = {`FCPS_IC_NORMAL, 3'h0, head_side_choice, drive_pick};
          next_result_status_second = 8'h00;
          if (drv_sector_err_i) begin
            next_result_status_first[7:6]            = `FCPS_IC_ABNORMAL;
            next_result_status_second[`FCPS_DERR_BIT] = 1'b1;
            next_state = FCPS_RESULT; // RULE4
          end else if (!last_sect) begin
            next_param[`FCPS_SLOT_REC] = 8'(param[`FCPS_SLOT_REC] + 1'b1);
          end else if (multi_track_flag && !head_side_choice) begin
            // Multi-track carries on with side 1 from the first record
            next_param[`FCPS_SLOT_DRV][`FCPS_HDS_BIT] = 1'b1; // RULE2
            next_param[`FCPS_SLOT_HEAD] = 8'h01;
            next_param[`FCPS_SLOT_REC]  = `FCPS_FIRST_REC;
          end else begin
            next_state = FCPS_RESULT; // RULE4
          end
          if (next_state == FCPS_RESULT) begin
            next_res_len = `FCPS_SECT_RESULTS; // RULE4
            next_int     = 1'b1;
          end
        end
      end
      FCPS_STEP: begin
        next_step_cnt = 16'(step_cnt + 1'b1);
        next_step     = (step_cnt < 16'(STEP_CYC));
        // Ends only between pulses so the drive never sees a runt step
        if ((step_cnt == 16'h0000) && (drv_track0_i || (steps == 8'(RECAL_STEPS)))) begin
          next_step        = 1'b0;
          next_seek_status = {`FCPS_IC_NORMAL, 1'b1, 2'h0, head_side_choice, drive_pick};
          if (!drv_track0_i) begin
            next_seek_status[7:6]          = `FCPS_IC_ABNORMAL;
            next_seek_status[`FCPS_EQC_BIT] = 1'b1;
          end
          next_pcn[drive_pick] = 8'h00; // RULE5
          next_seek_drive = drive_pick;
          next_seek_pend  = 1'b1;
          next_int        = 1'b1; // RULE5
          next_state      = FCPS_IDLE;
        end else if (step_cnt == 16'(2 * STEP_CYC - 1)) begin
          next_step_cnt = 16'h0000;
          next_steps    = 8'(steps + 1'b1);
        end
      end
      FCPS_RESULT: begin
        next_host_data = res_byte;
        next_res_ok    = !pop;
        if (pop) begin
          next_int     = 1'b0;
          next_res_idx = 3'(res_idx + 1'b1);
          if (3'(res_idx + 1'b1) == res_len) begin
            next_state = FCPS_IDLE; // RULE7
          end
        end
      end
      default: next_state = FCPS_IDLE;
    endcase
  end

  // =====================================================================
  // Registers
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      state                  <= FCPS_IDLE;
      op                     <= FCPS_OP_BAD;
      param                  <= '{default: 8'h00};
      present_cylinder                    <= '{default: 8'h00};
      pidx                   <= 4'h0;
      pneed                  <= 4'h0;
      multi_track_flag       <= 1'b0;
      double_density_flag    <= 1'b0;
      length_or_count_choice <= 1'b0;
      sect_cnt               <= 8'h00;
      result_status_first    <= 8'h00;
      result_status_second   <= 8'h00;
      seek_status            <= 8'h00;
      seek_drive             <= 2'h0;
      seek_pend              <= 1'b0;
      res_idx                <= 3'h0;
      res_len                <= 3'h0;
      res_ok                 <= 1'b0;
      host_data_o            <= 8'h00;
      int_o                  <= 1'b0;
      step_cnt               <= 16'h0000;
      steps                  <= 8'h00;
      drv_step_o             <= 1'b0;
    end else begin
      state                  <= next_state;
      op                     <= next_op;
      param                  <= next_param;
      present_cylinder                    <= next_pcn;
      pidx                   <= next_pidx;
      pneed                  <= next_pneed;
      multi_track_flag       <= next_multi_track_flag;
      double_density_flag    <= next_double_density_flag;
      length_or_count_choice <= next_length_or_count_choice;
      sect_cnt               <= next_sect_cnt;
      result_status_first    <= next_result_status_first;
      result_status_second   <= next_result_status_second;
      seek_status            <= next_seek_status;
      seek_drive             <= next_seek_drive;
      seek_pend              <= next_seek_pend;
      res_idx                <= next_res_idx;
      res_len                <= next_res_len;
      res_ok                 <= next_res_ok;
      host_data_o            <= next_host_data;
      int_o                  <= next_int;
      step_cnt               <= next_step_cnt;
      steps                  <= next_steps;
      drv_step_o             <= next_step;
    end
  end
endmodule

//--- sim/fcps_sequencer_props.sv
// Port checker for the floppy command sequencer.
// Assumes binding into fcps_sequencer, one clock domain.
`timescale 1ns/1ps
module fcps_sequencer_props #(
  parameter int STEP_CYC = 2
) (
  input wire logic       clock_i, rstn_i, host_wr_i, host_wr_ready_o, host_rd_i, host_rd_ready_o,
  input wire logic       busy_o, exec_o, int_o, xfer_ready_o, drv_valid_o, drv_write_o,
  input wire logic       drv_deleted_o, drv_verify_o, drv_step_o, drv_dir_o,
  input wire logic [7:0] host_data_i, host_data_o
);
  int unsigned step_len;
  int unsigned next_step_len;
  logic        cmd_ok;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  // ==========
  // Helpers
  assign cmd_ok = host_wr_i && host_wr_ready_o && !busy_o;
  always_comb next_step_len = drv_step_o ? step_len + 1 : 0;
  always_ff @(posedge clock_i) step_len <= rstn_i ? next_step_len : 0;
  // ==========
  // Properties
  AST_VFY_NODATA: assert property (drv_verify_o |-> !drv_valid_o && !xfer_ready_o) else $error("verify data");
  AST_DATA_EXEC: assert property (drv_valid_o |-> exec_o) else $error("data outside exec");
  AST_CMD_PARAM: assert property (cmd_ok && host_data_i == 8'h45 |=> busy_o && host_wr_ready_o) else $error("param");
  AST_RD_GAP: assert property (host_rd_i && host_rd_ready_o |=> !host_rd_ready_o) else $error("pop gap");
  AST_INT_POP: assert property (int_o && busy_o && host_rd_i && host_rd_ready_o |=> !int_o) else $error("int");
  AST_STEP_LEN: assert property ($fell(drv_step_o) |-> step_len == STEP_CYC) else $error("step len");
  AST_STEP_OUT: assert property (drv_step_o |-> exec_o && !drv_dir_o && !drv_write_o) else $error("step");
  AST_SENSE: assert property (cmd_ok && host_data_i == 8'h08 |=> !int_o && busy_o) else $error("sense");
  AST_BAD_CMD: assert property (cmd_ok && host_data_i == 8'hFF |=> !host_rd_ready_o ##1
    host_rd_ready_o && host_data_o == 8'h80) else $error("invalid");
  AST_RD_LATE: assert property (host_rd_ready_o |-> busy_o && !exec_o) else $error("early result");
  COV_RECAL: cover property ($rose(int_o) && !busy_o);
  COV_WRDEL: cover property (drv_valid_o && drv_deleted_o);
  COV_POP: cover property (host_rd_i && host_rd_ready_o && host_data_o == 8'h80);
endmodule

bind fcps_sequencer fcps_sequencer_props #(.STEP_CYC(STEP_CYC)) props (.clock_i, .rstn_i, .host_wr_i,
  .host_wr_ready_o, .host_rd_i, .host_rd_ready_o, .busy_o, .exec_o, .int_o, .xfer_ready_o, .drv_valid_o,
  .drv_write_o, .drv_deleted_o, .drv_verify_o, .drv_step_o, .drv_dir_o, .host_data_i, .host_data_o);

//--- sim/fcps_drive_model.sv
// Floppy drive stand-in for the sequencer's drive port.
// Assumes the bench sets stalls, sector errors and distance home.
`timescale 1ns/1ps
module fcps_drive_model #(
  parameter int SECT = 4
) (
  input  wire logic       clock_i, rstn_i, clr_i, stall_i, err_i,
  input  wire logic       drv_valid_o, drv_verify_o, drv_step_o,
  input  wire logic [7:0] drv_data_o, home_i,
  output logic            drv_ready_i, drv_sector_done_i, drv_sector_err_i, drv_track0_i, bad_o
);
  int         cnt, steps;
  logic [7:0] want;
  logic       step_q, tick;
  // ==========
  // Drive
  assign drv_ready_i = !stall_i; // Stalling lets the buffer fill
  assign drv_sector_err_i = err_i;
  assign drv_track0_i = steps >= int'(home_i);
  assign tick = (drv_valid_o && drv_ready_i) || drv_verify_o;
  always @(posedge clock_i) begin
    step_q <= drv_step_o;
    drv_sector_done_i <= rstn_i && tick && cnt == SECT - 1;
    if (!rstn_i || clr_i) begin
      steps <= 0;
      cnt <= 0;
      want <= 8'h00;
      bad_o <= 1'b0;
    end else begin
      if (drv_step_o && !step_q) steps <= steps + 1;
      if (tick) cnt <= (cnt == SECT - 1) ? 0 : cnt + 1;
      if (drv_valid_o && drv_ready_i) begin
        bad_o <= bad_o | (drv_data_o !== want);
        want <= want + 8'h01;
      end
    end
  end
endmodule

//--- sim/fcps_sequencer_test.sv
// Self-checking bench for the floppy command sequencer.
// Assumes the drive model and port checker are compiled alongside.
`timescale 1ns/1ps
module fcps_sequencer_test;
  logic       clock_i = 1'b0, rstn_i = 1'b0, host_wr_i = 1'b0, host_rd_i = 1'b0, xfer_valid_i = 1'b0;
  logic       stall = 1'b0, err = 1'b0, clr = 1'b0, bad, hd;
  logic [1:0] sel;
  logic [7:0] host_data_i = 8'h00, xfer_data_i = 8'h00, home = 8'h00, nb, host_data_o, drv_data_o;
  logic       host_wr_ready_o, host_rd_ready_o, busy_o, exec_o, int_o, xfer_ready_o, drv_valid_o;
  logic       drv_ready_i, drv_sector_done_i, drv_sector_err_i, drv_track0_i, drv_dens_o;
  logic       drv_write_o, drv_deleted_o, drv_verify_o, drv_step_o, drv_dir_o;
  logic [7:0] bad_codes[3] = '{8'hFF, 8'h00, 8'h08};
  int         errors = 0, samples_checked = 0, n, got;

  fcps_sequencer #(.STEP_CYC(2), .RECAL_STEPS(3)) dut (.clock_i, .rstn_i, .host_data_i, .host_wr_i,
    .host_wr_ready_o, .host_data_o, .host_rd_i, .host_rd_ready_o, .busy_o, .exec_o, .int_o, .xfer_data_i,
    .xfer_valid_i, .xfer_ready_o, .drv_data_o, .drv_valid_o, .drv_ready_i, .drv_sector_done_i,
    .drv_sector_err_i, .drv_track0_i, .drv_sel_o(sel), .drv_head_o(hd), .drv_cyl_o(), .drv_rec_o(),
    .drv_size_o(), .drv_gap_o(), .drv_dens_o, .drv_write_o, .drv_deleted_o, .drv_verify_o,
    .drv_step_o, .drv_dir_o);
  fcps_drive_model dm (.clock_i, .rstn_i, .clr_i(clr), .stall_i(stall), .err_i(err), .drv_valid_o,
    .drv_verify_o, .drv_step_o, .drv_data_o, .home_i(home), .drv_ready_i, .drv_sector_done_i,
    .drv_sector_err_i, .drv_track0_i, .bad_o(bad));

  always #25 clock_i = ~clock_i;

  // ==========
  // Tasks
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("FAIL %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic cmd(input logic [7:0] q[$]);
    foreach (q[i]) begin
      host_data_i <= q[i];
      host_wr_i <= 1'b1;
      @(posedge clock_i);
    end
    host_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] e);
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (host_rd_ready_o !== 1'b1 && n < 50);
    chk({7'h0, host_rd_ready_o}, 8'h01);
    chk(host_data_o, e);
    host_rd_i <= 1'b1;
    @(posedge clock_i);
    host_rd_i <= 1'b0;
  endtask
  task automatic res(input logic [7:0] q[$]);
    foreach (q[i]) rd(q[i]);
  endtask
  task automatic push(input int cnt);
    got = 0;
    n = 0;
    xfer_data_i <= nb;
    xfer_valid_i <= 1'b1;
    while (got < cnt && n < 8) begin
      @(posedge clock_i);
      if (xfer_ready_o === 1'b1) begin
        got++;
        n = 0;
        nb = nb + 8'h01;
        xfer_data_i <= nb;
      end else n++;
    end
    xfer_valid_i <= 1'b0;
  endtask
  task automatic setup(input logic s, input logic e, input logic [7:0] h);
    stall <= s;
    err <= e;
    home <= h;
    nb = 8'h00;
    clr <= 1'b1;
    @(posedge clock_i);
    clr <= 1'b0;
  endtask
  task automatic wt;
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (int_o !== 1'b1 && n < 400);
  endtask
  task automatic finish_test;
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // ==========
  // Tests
  initial begin
    repeat (5) @(posedge clock_i);
    rstn_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    chk({4'h0, busy_o, int_o, host_rd_ready_o, host_wr_ready_o}, 8'h01);
    foreach (bad_codes[i]) begin
      cmd('{bad_codes[i]});
      rd(8'h80);
      @(posedge clock_i);
      chk({7'h0, host_wr_ready_o}, 8'h01);
    end
    $display("test invalid ended");
    setup(1'b0, 1'b0, 8'h00);
    cmd('{8'h45, 8'h05, 8'h0A, 8'h01, 8'h03, 8'h02, 8'h04, 8'h1B, 8'hFF});
    push(8);
    chk({5'h0, drv_deleted_o, drv_dens_o, drv_write_o}, 8'h03);
    chk({5'h0, hd, sel}, 8'h05);
    res('{8'h05, 8'h00, 8'h00, 8'h0A, 8'h01, 8'h04, 8'h02});
    chk({6'h0, bad, int_o}, 8'h00);
    $display("test write ended");
    setup(1'b1, 1'b0, 8'h00);
    cmd('{8'hC9, 8'h00, 8'h02, 8'h00, 8'h02, 8'h02, 8'h02, 8'h1B, 8'hFF});
    push(12);
    chk(got[7:0], 8'h09);
    chk({6'h0, drv_dens_o, drv_deleted_o}, 8'h03);
    stall <= 1'b0;
    @(posedge clock_i);
    push(3);
    res('{8'h04, 8'h00, 8'h00, 8'h02, 8'h01, 8'h02, 8'h02});
    chk({7'h0, bad}, 8'h00);
    $display("test deleted ended");
    setup(1'b0, 1'b0, 8'h00);
    cmd('{8'h16, 8'h81, 8'h05, 8'h00, 8'h01, 8'h02, 8'h09, 8'h1B, 8'h02});
    push(1);
    chk(got[7:0], 8'h00);
    res('{8'h01, 8'h00, 8'h00, 8'h05, 8'h00, 8'h02, 8'h02});
    setup(1'b0, 1'b1, 8'h00);
    cmd('{8'h36, 8'h00, 8'h07, 8'h00, 8'h03, 8'h02, 8'h09, 8'h1B, 8'h80});
    res('{8'h40, 8'h20, 8'h00, 8'h07, 8'h00, 8'h03, 8'h02});
    $display("test verify ended");
    setup(1'b0, 1'b0, 8'h02);
    cmd('{8'h07, 8'h02});
    wt();
    @(posedge clock_i);
    chk({5'h0, int_o, host_rd_ready_o, busy_o}, 8'h04);
    cmd('{8'h08});
    res('{8'h22, 8'h00});
    setup(1'b0, 1'b0, 8'h09);
    cmd('{8'h07, 8'h03});
    wt();
    cmd('{8'h08});
    rd(8'h73);
    $display("test recal ended");
    finish_test();
  end

  initial begin
    #200us;
    errors++;
    $display("FAIL %0t watchdog", $time);
    finish_test();
  end
endmodule
